// File: gct_unit.sv
// one counter unit: prescaler, down counter, clock select, gating and mode logic
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module gct_unit
	import gct_pkg::*;
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic sys_rst,
	input  wire logic clk_en,
	// configuration
	gct_cfg_if.unit   cfg,
	// pins
	input  wire logic ext_clk,
	input  wire logic ext_gate_in,
	output logic      tmr_out
);
	logic                 half_tick;
	logic                 ext_clk_q;
	logic                 gate_q;
	logic                 tick;
	logic                 pre_uf;
	logic                 enabled;
	logic                 armed;
	logic [GCT_PRE_W-1:0] pre;
	logic [GCT_CNT_W-1:0] cnt;
	logic                 tc;
	logic                 cmp_hit;
	logic                 cap_evt;
	logic                 gate_rise;
	logic                 gate_fall;

	// system clock halved for the internal source
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			half_tick <= 1'b0;
		else if (clk_en)
			half_tick <= ~half_tick;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ext_clk_q <= 1'b0;
			gate_q    <= 1'b0;
		end else if (clk_en) begin
			ext_clk_q <= ext_clk;
			gate_q    <= ext_gate_in;
		end
	end

	assign gate_rise = gct_rise(ext_gate_in, gate_q);
	assign gate_fall = gct_rise(gate_q, ext_gate_in);
	// event mode counts rising gate edges; others use the selected clock source
	assign tick = (cfg.mode == GCT_M_EVENT) ? gate_rise :
		(cfg.ext_clk_sel ? gct_rise(ext_clk, ext_clk_q) : half_tick);
	// external gating holds counting to the gate level except in event mode; width mode measures the high phase
	assign enabled = cfg.run & armed & (~cfg.ext_gate | cfg.mode == GCT_M_EVENT | ext_gate_in);
	assign pre_uf  = enabled & tick & (pre == '0);
	assign tc      = pre_uf & (cnt == '0);
	assign cmp_hit = pre_uf & (cnt == cfg.cmp);
	assign cap_evt = (cfg.mode == GCT_M_CAPTURE | cfg.mode == GCT_M_PERIOD) ? gate_rise :
		(cfg.mode == GCT_M_WIDTH) ? gate_fall : 1'b0;

	// one-shot disarms after terminal count until software reloads
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			armed <= 1'b1;
		else if (clk_en) begin
			if (cfg.load)
				armed <= 1'b1;
			else if (tc && cfg.mode == GCT_M_ONESHOT)
				armed <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			pre <= GCT_PRE_RST;
		else if (clk_en) begin
			if (cfg.load || pre_uf)
				pre <= cfg.pre_load;
			else if (enabled && tick)
				pre <= pre - 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			cnt <= GCT_CNT_RST;
		else if (clk_en) begin
			if (cfg.load || tc || (cfg.mode == GCT_M_PERIOD && cap_evt))
				cnt <= cfg.cnt_load;
			else if (pre_uf)
				cnt <= cnt - 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			cfg.capture <= '0;
		else if (clk_en && cap_evt)
			cfg.capture <= cnt;
	end

	// output pin per mode, only when the output is enabled
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			tmr_out <= 1'b0;
		else if (clk_en) begin
			if (!cfg.out_en || cfg.load)
				tmr_out <= 1'b0;
			else unique case (cfg.mode)
				GCT_M_SQUARE:  if (tc) tmr_out <= ~tmr_out;
				GCT_M_DUTY:    if (tc) tmr_out <= 1'b0; else if (cmp_hit) tmr_out <= 1'b1;
				GCT_M_ONESHOT: tmr_out <= cfg.run & armed & ~tc;
				GCT_M_COMPARE: if (cmp_hit) tmr_out <= ~tmr_out;
				default:       if (tc) tmr_out <= ~tmr_out;
			endcase
		end
	end

	assign cfg.count       = cnt;
	assign cfg.event_pulse = {cap_evt & clk_en, cmp_hit & clk_en, tc & clk_en};

	a_prescale_reload: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && pre_uf && !cfg.load |=> pre == $past(cfg.pre_load))
		else $error("prescaler did not reload after underflow");
	a_count_step: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && pre_uf && !tc && !cfg.load && !cap_evt |=> cnt == $past(cnt) - 16'h0001)
		else $error("counter did not step on prescaler underflow");
	a_hold_stopped: assert property (@(posedge core_clk) disable iff (sys_rst)
		!cfg.run && !cfg.load && !cap_evt |=> cnt == $past(cnt) && pre == $past(pre))
		else $error("counter moved while stopped");
	a_oneshot_disarm: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && tc && cfg.mode == GCT_M_ONESHOT && !cfg.load |=> !armed)
		else $error("one-shot not disarmed at terminal count");
endmodule // gct_unit
`default_nettype wire

// File: gct_pkg.sv
// package: register map, field positions, modes and constants of the counter/timer block
`default_nettype none
package gct_pkg;
	localparam int          GCT_ADDR_W     = 6;
	localparam int          GCT_DATA_W     = 32;
	localparam int          GCT_CNT_W      = 16;
	localparam int          GCT_PRE_W      = 8;
	localparam int          GCT_UNITS      = 2;
	// per-unit register offsets (byte addresses), unit 1 adds GCT_UNIT_STRIDE
	localparam logic [5:0]  GCT_OFF_CTRL   = 6'h00;
	localparam logic [5:0]  GCT_OFF_PRE    = 6'h04;
	localparam logic [5:0]  GCT_OFF_CNT    = 6'h08;
	localparam logic [5:0]  GCT_OFF_CMP    = 6'h0c;
	localparam logic [5:0]  GCT_OFF_CAP    = 6'h10;
	localparam logic [5:0]  GCT_OFF_STAT   = 6'h14;
	localparam logic [5:0]  GCT_OFF_CLR    = 6'h18;
	localparam logic [5:0]  GCT_OFF_IEN    = 6'h1c;
	localparam logic [5:0]  GCT_UNIT_STRIDE = 6'h20;
	// control register fields
	localparam int          GCT_C_RUN      = 0;
	localparam int          GCT_C_EXTCLK   = 1;
	localparam int          GCT_C_EXTGATE  = 2;
	localparam int          GCT_C_OUTEN    = 3;
	localparam int          GCT_C_MODE_LO  = 4;
	localparam int          GCT_C_MODE_W   = 3;
	localparam logic [6:0]  GCT_CTRL_RST   = 7'h00;
	// status bits
	localparam int          GCT_ST_W       = 3;
	localparam int          GCT_S_TC       = 0;
	localparam int          GCT_S_CMP      = 1;
	localparam int          GCT_S_CAP      = 2;
	localparam logic [15:0] GCT_CNT_RST    = 16'hffff;
	localparam logic [7:0]  GCT_PRE_RST    = 8'hff;

	typedef enum logic [2:0] {
		GCT_M_CAPTURE = 3'b000,
		GCT_M_COMPARE = 3'b001,
		GCT_M_SQUARE  = 3'b010,
		GCT_M_DUTY    = 3'b011,
		GCT_M_ONESHOT = 3'b100,
		GCT_M_EVENT   = 3'b101,
		GCT_M_PERIOD  = 3'b110,
		GCT_M_WIDTH   = 3'b111
	} gct_mode_t;

	// rising edge of a sampled level
	function automatic logic gct_rise(input logic now, input logic prev);
		return now & ~prev;
	endfunction
endpackage
`default_nettype wire

// File: gct_cfg_if.sv
// interface: configuration and status between register file and one counter unit
`timescale 1ns/1ps
`default_nettype none
interface gct_cfg_if;
	import gct_pkg::*;
	logic                 run;
	logic                 ext_clk_sel;
	logic                 ext_gate;
	logic                 out_en;
	gct_mode_t            mode;
	logic [GCT_PRE_W-1:0] pre_load;
	logic [GCT_CNT_W-1:0] cnt_load;
	logic [GCT_CNT_W-1:0] cmp;
	logic                 load;
	logic [GCT_CNT_W-1:0] count;
	logic [GCT_CNT_W-1:0] capture;
	logic [GCT_ST_W-1:0]  event_pulse;
	modport regs (output run, ext_clk_sel, ext_gate, out_en, mode, pre_load, cnt_load, cmp, load,
		input count, capture, event_pulse);
	modport unit (input run, ext_clk_sel, ext_gate, out_en, mode, pre_load, cnt_load, cmp, load,
		output count, capture, event_pulse);
endinterface
`default_nettype wire

// File: gct_top.sv
// top: register file, interrupt logic and two counter units
`timescale 1ns/1ps
`default_nettype none
module gct_top
	import gct_pkg::*;
(
	// clock, reset, enable
	input  wire logic                  core_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  clk_en,
	// register port
	input  wire logic [GCT_ADDR_W-1:0] reg_addr,
	input  wire logic [GCT_DATA_W-1:0] reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [GCT_DATA_W-1:0] reg_rdata,
	// timer pins, one per unit
	input  wire logic [GCT_UNITS-1:0]  ext_clk,
	input  wire logic [GCT_UNITS-1:0]  ext_gate,
	output logic      [GCT_UNITS-1:0]  tmr_out,
	// interrupt
	output logic                       irq
);
	import gct_pkg::*;

	logic [GCT_ST_W-1:0] status [GCT_UNITS];
	logic [GCT_ST_W-1:0] ien    [GCT_UNITS];
	logic [GCT_UNITS-1:0] irq_unit;
	logic [GCT_DATA_W-1:0] rd_unit [GCT_UNITS];

	gct_cfg_if cfg [GCT_UNITS] ();

	for (genvar u = 0; u < GCT_UNITS; u++) begin : g_unit
		logic [6:0]  ctrl;
		logic [5:0]  base;
		logic        sel;
		logic [5:0]  off;
		logic [GCT_CNT_W-1:0]  cnt_hold;
		logic [GCT_DATA_W-1:0] rd_word;

		assign base = (u == 0) ? 6'h00 : GCT_UNIT_STRIDE;
		assign sel  = (reg_addr & GCT_UNIT_STRIDE) == base;
		assign off  = reg_addr & ~GCT_UNIT_STRIDE;

		always_ff @(posedge core_clk or posedge sys_rst) begin
			if (sys_rst) begin
				ctrl            <= GCT_CTRL_RST;
				cfg[u].pre_load <= GCT_PRE_RST;
				cnt_hold        <= GCT_CNT_RST;
				cfg[u].cmp      <= '0;
				ien[u]          <= '0;
			end else if (clk_en && reg_wr && sel) begin
				if (off == GCT_OFF_CTRL) ctrl <= reg_wdata[6:0];
				if (off == GCT_OFF_PRE)  cfg[u].pre_load <= reg_wdata[GCT_PRE_W-1:0];
				if (off == GCT_OFF_CNT)  cnt_hold <= reg_wdata[GCT_CNT_W-1:0];
				if (off == GCT_OFF_CMP)  cfg[u].cmp <= reg_wdata[GCT_CNT_W-1:0];
				if (off == GCT_OFF_IEN)  ien[u] <= reg_wdata[GCT_ST_W-1:0];
			end
		end

		// writing the counter register also loads prescaler and counter
		assign cfg[u].load        = clk_en & reg_wr & sel & (off == GCT_OFF_CNT);
		// the write data bypass the held value so the load edge takes the new count, not the old one
		assign cfg[u].cnt_load    = cfg[u].load ? reg_wdata[GCT_CNT_W-1:0] : cnt_hold;
		assign cfg[u].run         = ctrl[GCT_C_RUN];
		assign cfg[u].ext_clk_sel = ctrl[GCT_C_EXTCLK];
		assign cfg[u].ext_gate    = ctrl[GCT_C_EXTGATE];
		assign cfg[u].out_en      = ctrl[GCT_C_OUTEN];
		assign cfg[u].mode        = gct_mode_t'(ctrl[GCT_C_MODE_LO +: GCT_C_MODE_W]);

		// sticky status: a new event wins over a clear in the same cycle
		always_ff @(posedge core_clk or posedge sys_rst) begin
			if (sys_rst)
				status[u] <= '0;
			else if (clk_en) begin
				if (reg_wr && sel && off == GCT_OFF_CLR)
					status[u] <= (status[u] & ~reg_wdata[GCT_ST_W-1:0]) | cfg[u].event_pulse;
				else
					status[u] <= status[u] | cfg[u].event_pulse;
			end
		end
		assign irq_unit[u] = |(status[u] & ien[u]);

		// read word per unit; the interface array may only be indexed by the generate constant
		always_comb begin
			unique case (off)
				GCT_OFF_CTRL: rd_word = {25'h0, ctrl};
				GCT_OFF_PRE:  rd_word = {24'h0, cfg[u].pre_load};
				GCT_OFF_CNT:  rd_word = {16'h0, cfg[u].count};
				GCT_OFF_CMP:  rd_word = {16'h0, cfg[u].cmp};
				GCT_OFF_CAP:  rd_word = {16'h0, cfg[u].capture};
				GCT_OFF_STAT: rd_word = {29'h0, status[u]};
				GCT_OFF_IEN:  rd_word = {29'h0, ien[u]};
				default:      rd_word = '0;
			endcase
		end
		assign rd_unit[u] = rd_word;

		// unit 1 may take unit 0's output as its clock over the board
		gct_unit u_unit (
			.core_clk    (core_clk),
			.sys_rst     (sys_rst),
			.clk_en      (clk_en),
			.cfg         (cfg[u]),
			.ext_clk     (ext_clk[u]),
			.ext_gate_in (ext_gate[u]),
			.tmr_out     (tmr_out[u])
		);

		a_status_sticky: assert property (@(posedge core_clk) disable iff (sys_rst)
			clk_en && cfg[u].event_pulse[GCT_S_TC] |=> status[u][GCT_S_TC])
			else $error("terminal count did not set status");
	end

	assign irq = |irq_unit;

	// read data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			reg_rdata <= '0;
		else if (clk_en) begin
			reg_rdata <= '0;
			if (reg_rd)
				reg_rdata <= rd_unit[reg_addr[5]];
		end
	end

	a_irq_level: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && !reg_wr && ((cfg[0].event_pulse & ien[0]) != '0 || (cfg[1].event_pulse & ien[1]) != '0)
		|=> irq)
		else $error("enabled event did not raise the interrupt");
	a_read_zero_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && !reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data present without read strobe");
endmodule // gct_top
`default_nettype wire

// File: gct_pins_model.sv
// far-side model: external clock and gate pins plus the board cascade link
`timescale 1ns/1ps
`default_nettype none
module gct_pins_model (
	// clock
	input  wire logic       core_clk,
	// board wiring
	input  wire logic       cascade,
	input  wire logic [1:0] tmr_out,
	// pins to the block
	output logic      [1:0] ext_clk,
	output logic      [1:0] ext_gate
);
	logic [1:0] clk_lvl;
	initial clk_lvl = 2'h0;
	initial ext_gate = 2'h0;
	// unit 0 output may clock unit 1
	assign ext_clk = {cascade ? tmr_out[0] : clk_lvl[1], clk_lvl[0]};
	// edges two or three cycles apart so a synchronised level is never missed; the clock stands still between bursts
	task automatic pulse(input int u, input int n);
		repeat (n) begin
			@(posedge core_clk);
			clk_lvl[u] <= 1'b1;
			repeat (2) @(posedge core_clk);
			clk_lvl[u] <= 1'b0;
			repeat (2) @(posedge core_clk);
		end
	endtask
	// start and stop stimulus held as a level
	task automatic set_gate(input int u, input logic v);
		@(posedge core_clk);
		ext_gate[u] <= v;
	endtask
endmodule // gct_pins_model
`default_nettype wire

// File: testbench.sv
// self-checking bench for the counter/timer top
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import gct_pkg::*;
	localparam logic [31:0] M = 32'hffffffff;
	localparam logic [5:0]  U1 = GCT_UNIT_STRIDE;
	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        clk_en = 1'b1;
	logic [5:0]  reg_addr = 6'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        cascade = 1'b0;
	logic [31:0] reg_rdata;
	logic [1:0]  ext_clk;
	logic [1:0]  ext_gate;
	logic [1:0]  tmr_out;
	logic        irq;
	logic [31:0] v;
	logic [31:0] d;
	logic [31:0] l;
	int          seed = 92;
	int          err_count = 0;
	int          compares = 0;
	int          cyc = 0;
	int          p;
	int          c;
	int          t;

	always #2 core_clk = ~core_clk;

	gct_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ext_clk(ext_clk), .ext_gate(ext_gate), .tmr_out(tmr_out), .irq(irq));
	gct_pins_model pins (.core_clk(core_clk), .cascade(cascade), .tmr_out(tmr_out),
		.ext_clk(ext_clk), .ext_gate(ext_gate));

	function automatic int period(input int pre, input int cnt);
		return (pre + 1) * (cnt + 1) * 2;
	endfunction
	function automatic logic [31:0] near(input logic [31:0] a, input logic [31:0] e);
		return {31'h0, (a + 2 >= e) && (a <= e + 2)};
	endfunction

	task automatic summarize();
		$display("checks %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] w);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= w;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdchk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
		chk(d & m, e);
	endtask
	task automatic irqchk(input logic e);
		@(posedge core_clk);
		#1;
		chk({31'h0, irq}, {31'h0, e});
	endtask

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			summarize();
		end
	end

	initial begin
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		rdchk(GCT_OFF_CTRL, M, 32'h0);
		rdchk(GCT_OFF_PRE, M, 32'hff);
		rdchk(GCT_OFF_CNT, M, 32'hffff);
		rdchk(GCT_OFF_CLR, M, 32'h0);
		v = $random(seed);
		wr(GCT_OFF_CMP, v);
		rdchk(GCT_OFF_CMP, M, v & 32'hffff);
		wr(GCT_OFF_PRE, v);
		@(posedge core_clk);
		clk_en <= 1'b0;
		wr(GCT_OFF_PRE, ~v);
		@(posedge core_clk);
		clk_en <= 1'b1;
		rdchk(GCT_OFF_PRE, M, v & 32'hff);
		// terminal count from the halved system clock
		p = 1 + ($unsigned($random(seed)) % 3);
		c = 2 + ($unsigned($random(seed)) % 6);
		t = period(p, c);
		wr(GCT_OFF_PRE, p);
		wr(GCT_OFF_CNT, c);
		wr(GCT_OFF_CTRL, 32'h29);
		repeat (t - 6) @(posedge core_clk);
		rdchk(GCT_OFF_STAT, 32'h1, 32'h0);
		chk({30'h0, tmr_out}, 32'h0);
		repeat (6) @(posedge core_clk);
		rdchk(GCT_OFF_STAT, 32'h1, 32'h1);
		chk({30'h0, tmr_out}, 32'h1);
		wr(GCT_OFF_CTRL, 32'h0);
		wr(GCT_OFF_IEN, 32'h1);
		irqchk(1'b1);
		wr(GCT_OFF_IEN, 32'h0);
		irqchk(1'b0);
		wr(GCT_OFF_IEN, 32'h1);
		wr(GCT_OFF_CLR, 32'h7);
		irqchk(1'b0);
		// external clock, then gated by the stimulus pin
		l = 32'h100 + ($unsigned($random(seed)) % 32'hff00);
		wr(GCT_OFF_PRE, 32'h0);
		wr(GCT_OFF_CNT, l);
		wr(GCT_OFF_CTRL, 32'h3);
		pins.pulse(0, 5);
		rdchk(GCT_OFF_CNT, M, l - 5);
		wr(GCT_OFF_CNT, l);
		wr(GCT_OFF_CTRL, 32'h7);
		pins.pulse(0, 3);
		rdchk(GCT_OFF_CNT, M, l);
		pins.set_gate(0, 1'b1);
		pins.pulse(0, 3);
		rdchk(GCT_OFF_CNT, M, l - 3);
		// cascade: unit 0 square wave clocks unit 1, one count per output rise
		cascade <= 1'b1;
		wr(U1 + GCT_OFF_PRE, 32'h0);
		wr(U1 + GCT_OFF_CNT, l);
		wr(U1 + GCT_OFF_CTRL, 32'h3);
		wr(GCT_OFF_CNT, 32'h1);
		wr(GCT_OFF_CTRL, 32'h29);
		repeat (80) @(posedge core_clk);
		wr(GCT_OFF_CTRL, 32'h0);
		rdchk(U1 + GCT_OFF_CNT, 32'hffff0000, 32'h0);
		chk(near(l - d, 80 / period(0, 1) / 2), 32'h1);
		v = d;
		for (int m = 0; m < 8; m++) begin
			wr(U1 + GCT_OFF_CTRL, m << 4);
			rdchk(U1 + GCT_OFF_CTRL, M, m << 4);
		end
		// running on the idle external clock keeps the count still, so the capture must equal it
		wr(U1 + GCT_OFF_CTRL, 32'h3);
		pins.set_gate(1, 1'b1);
		repeat (6) @(posedge core_clk);
		rdchk(U1 + GCT_OFF_STAT, 32'h4, 32'h4);
		rdchk(U1 + GCT_OFF_CAP, M, v);
		// event counting: one step per gate rise
		wr(U1 + GCT_OFF_CNT, l);
		wr(U1 + GCT_OFF_CTRL, 32'h51);
		repeat (3) begin
			pins.set_gate(1, 1'b0);
			pins.set_gate(1, 1'b1);
		end
		rdchk(U1 + GCT_OFF_CNT, M, l - 3);
		// one-shot: output high from start until terminal count, then stays low
		wr(GCT_OFF_CNT, 32'h1);
		wr(GCT_OFF_CTRL, 32'h49);
		@(posedge core_clk);
		#1;
		chk({30'h0, tmr_out}, 32'h1);
		repeat (20) @(posedge core_clk);
		#1;
		chk({30'h0, tmr_out}, 32'h0);
		summarize();
	end
endmodule // testbench
`default_nettype wire
